//--- design/acsp_pkg.sv
// package: constants and types for the audio control serial port
package acsp_pkg;
    // frame layout
    localparam int          FRAME_BITS   = 16;
    localparam int          ADDR_MSB     = 15;
    localparam int          ADDR_LSB     = 8;
    localparam int          DATA_MSB     = 7;
    localparam int          DATA_LSB     = 0;
    localparam logic [4:0]  BIT_CNT_LAST = 5'h10;
    localparam logic [4:0]  BIT_CNT_ZERO = 5'h00;
    // i2c slave addresses selected by the address strap
    localparam logic [6:0]  I2C_ADDR_LOW  = 7'h10;
    localparam logic [6:0]  I2C_ADDR_HIGH = 7'h70;
    // register indexes of the volume controls
    localparam logic [7:0]  REG_MONO_VOL  = 8'h02;
    localparam logic [7:0]  REG_LS_L_VOL  = 8'h03;
    localparam logic [7:0]  REG_LS_R_VOL  = 8'h04;
    localparam logic [7:0]  REG_HP_L_VOL  = 8'h05;
    localparam logic [7:0]  REG_HP_R_VOL  = 8'h06;
    localparam int          NUM_REGS      = 16;
    localparam int          REG_IDX_W     = 4;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    // volume code field and its meaning
    localparam int          VOL_MSB       = 4;
    localparam logic [4:0]  VOL_MUTE      = 5'h00;
    localparam logic [4:0]  VOL_MIN       = 5'h01;
    localparam logic [4:0]  VOL_MAX       = 5'h1F;
    localparam int          VOL_MIN_DB    = -56;
    localparam int          VOL_MAX_DB    = 5;
    localparam int          VOL_STEP_X2   = 4;
    typedef enum logic { ACSP_MODE_I2C, ACSP_MODE_SPI } acsp_mode_t;
endpackage

//--- design/acsp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acsp_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // data
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    // first flop feeds only the second
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            dout   <= RESET_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

//--- design/acsp_ctrl_port.sv
// spi control port with write-only configuration registers and volume decode
// Operation
// - strap low selects i2c slave, strap high selects three-wire spi slave; no i2c slave is built, strap low only clears spi_mode_q
// - registers take 8-bit values and are write only, no readback
// - device is slave only; host supplies clock and starts every transfer
// - enable held low by host; serial bit captured on rising serial clock
// - frame is exactly sixteen bits, most significant bit first
// - bits 15:8 are register address, bits 7:0 are written value
// - volume code one selects lowest unmuted gain, minus 56 dB
// - volume code zero mutes the output
// - highest volume code selects maximum gain, plus 5 dB
// - i2c address 0010000 with address strap low, 1110000 when high
`timescale 1ns/1ps
module acsp_ctrl_port (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // straps
    input  wire logic        mode_strap,
    input  wire logic        addr_strap,
    // spi pins
    input  wire logic        sclk,
    input  wire logic        sdi,
    input  wire logic        frame_select_low_n,
    // mode and i2c address status
    output logic             spi_mode_q,
    output logic [6:0]       i2c_addr_q,
    // write strobe
    output logic             wr_stb_q,
    output logic [7:0]       wr_addr_q,
    output logic [7:0]       wr_data_q,
    // volume outputs, signed gain in half-dB
    output logic [4:0]       ls_l_vol_q,
    output logic [4:0]       ls_r_vol_q,
    output logic [4:0]       hp_l_vol_q,
    output logic [4:0]       hp_r_vol_q,
    output logic [4:0]       mono_vol_q,
    output logic [4:0]       mute_q,
    output logic signed [7:0] ls_l_gain_q
);
    logic              sclk_s;
    logic              sdi_s;
    logic              sel_n_s;
    logic              mode_strap_s;
    logic              addr_strap_s;
    logic [1:0]        strap_wait_q;
    logic              sclk_d1_q;
    logic              strap_done_q;
    logic [15:0]       shift_q;
    logic [15:0]       frame_word;
    logic [4:0]        cnt_q;
    logic              sclk_rise;
    logic              bit_take;
    logic              frame_last;
    logic [7:0]        regs_q [acsp_pkg::NUM_REGS];
    logic [3:0]        reg_idx;
    logic              reg_we;
    logic signed [7:0] ls_l_gain_d;

    // pin synchronisers, serial clock idles low
    acsp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_sclk (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (sclk),
        .dout    (sclk_s)
    );

    // serial data pin
    acsp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_sdi (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (sdi),
        .dout    (sdi_s)
    );

    // frame select idles high, so no false frame after reset
    acsp_sync #(
        .RESET_VAL(1'b1)
    ) u_sync_sel (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (frame_select_low_n),
        .dout    (sel_n_s)
    );

    // interface select strap
    acsp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_mode (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (mode_strap),
        .dout    (mode_strap_s)
    );

    // slave address strap
    acsp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_addr (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (addr_strap),
        .dout    (addr_strap_s)
    );

    // strap pipeline fill; the strap flops hold reset values for two edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_wait_q <= 2'h0;
        end else begin
            strap_wait_q <= {strap_wait_q[0], 1'b1};
        end
    end

    // strap capture once synchronised levels are valid
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_done_q <= 1'b0;
            spi_mode_q   <= 1'b0;
            i2c_addr_q   <= acsp_pkg::I2C_ADDR_LOW;
        end else if (strap_wait_q[1] && !strap_done_q) begin
            strap_done_q <= 1'b1;
            spi_mode_q   <= mode_strap_s;
            i2c_addr_q   <= addr_strap_s ? acsp_pkg::I2C_ADDR_HIGH
                                         : acsp_pkg::I2C_ADDR_LOW;
        end
    end

    // serial clock edge detect
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d1_q <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d1_q;

    // next shift value, newest serial bit at the bottom
    assign frame_word = {shift_q[acsp_pkg::FRAME_BITS-2:0], sdi_s};
    // bit taken on rising serial clock inside a spi frame
    assign bit_take   = spi_mode_q && !sel_n_s && sclk_rise;
    assign frame_last = (cnt_q == acsp_pkg::BIT_CNT_LAST - 5'h01);

    // shift on rising edge while selected
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 16'h0000;
            cnt_q   <= acsp_pkg::BIT_CNT_ZERO;
        end else if (!spi_mode_q || sel_n_s) begin
            cnt_q <= acsp_pkg::BIT_CNT_ZERO;
        end else if (sclk_rise && cnt_q != acsp_pkg::BIT_CNT_LAST) begin
            shift_q <= frame_word;
            cnt_q   <= cnt_q + 5'h01;
        end
    end

    // commit once sixteen bits are in
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (bit_take && frame_last) begin
                // address high byte, data low byte
                wr_stb_q  <= 1'b1;
                wr_addr_q <= frame_word[acsp_pkg::ADDR_MSB:acsp_pkg::ADDR_LSB];
                wr_data_q <= frame_word[acsp_pkg::DATA_MSB:acsp_pkg::DATA_LSB];
            end
        end
    end

    // register index and write enable; addresses past the file are dropped
    assign reg_idx = wr_addr_q[acsp_pkg::REG_IDX_W-1:0];
    assign reg_we  = wr_stb_q && (wr_addr_q < 8'(acsp_pkg::NUM_REGS));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < acsp_pkg::NUM_REGS; i++) begin
                regs_q[i] <= acsp_pkg::REG_RESET;
            end
        end else if (reg_we) begin
            regs_q[reg_idx] <= wr_data_q;
        end
    end

    // volume codes copied out of their registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ls_l_vol_q <= acsp_pkg::VOL_MUTE;
            ls_r_vol_q <= acsp_pkg::VOL_MUTE;
            hp_l_vol_q <= acsp_pkg::VOL_MUTE;
            hp_r_vol_q <= acsp_pkg::VOL_MUTE;
            mono_vol_q <= acsp_pkg::VOL_MUTE;
        end else begin
            ls_l_vol_q <= regs_q[acsp_pkg::REG_LS_L_VOL[3:0]][acsp_pkg::VOL_MSB:0];
            ls_r_vol_q <= regs_q[acsp_pkg::REG_LS_R_VOL[3:0]][acsp_pkg::VOL_MSB:0];
            hp_l_vol_q <= regs_q[acsp_pkg::REG_HP_L_VOL[3:0]][acsp_pkg::VOL_MSB:0];
            hp_r_vol_q <= regs_q[acsp_pkg::REG_HP_R_VOL[3:0]][acsp_pkg::VOL_MSB:0];
            mono_vol_q <= regs_q[acsp_pkg::REG_MONO_VOL[3:0]][acsp_pkg::VOL_MSB:0];
        end
    end

    // zero code mutes, one flag per output
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mute_q <= 5'h1F;
        end else begin
            mute_q <= {ls_l_vol_q == acsp_pkg::VOL_MUTE,
                       ls_r_vol_q == acsp_pkg::VOL_MUTE,
                       hp_l_vol_q == acsp_pkg::VOL_MUTE,
                       hp_r_vol_q == acsp_pkg::VOL_MUTE,
                       mono_vol_q == acsp_pkg::VOL_MUTE};
        end
    end

    // left speaker gain in half-dB, zero while muted
    always_comb begin
        ls_l_gain_d = 8'sh00;
        if (ls_l_vol_q == acsp_pkg::VOL_MAX) begin
            ls_l_gain_d = 8'(2 * acsp_pkg::VOL_MAX_DB); // top code is pinned
        end else if (ls_l_vol_q != acsp_pkg::VOL_MUTE) begin
            ls_l_gain_d = 8'(2 * acsp_pkg::VOL_MIN_DB
                + acsp_pkg::VOL_STEP_X2 * (int'(ls_l_vol_q) - int'(acsp_pkg::VOL_MIN)));
        end
    end

    // gain register, lands with the mute flags
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ls_l_gain_q <= 8'sh00;
        end else begin
            ls_l_gain_q <= ls_l_gain_d;
        end
    end
endmodule

//--- verification/acsp_props.sv
// assertion checker for the control port outputs
`timescale 1ns/1ps
module acsp_props (
    // clock and reset
    input wire logic              mclk,
    input wire logic              reset_n,
    // watched pins and outputs
    input wire logic              frame_select_low_n,
    input wire logic              spi_mode_q,
    input wire logic              wr_stb_q,
    input wire logic [7:0]        wr_addr_q,
    input wire logic [7:0]        wr_data_q,
    input wire logic [4:0]        ls_l_vol_q,
    input wire logic [4:0]        mono_vol_q,
    input wire logic [4:0]        mute_q,
    input wire logic signed [7:0] ls_l_gain_q
);
    // all checks on the system clock
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_mode; wr_stb_q |-> spi_mode_q; endproperty
    a_mode: assert property (p_mode) else $error("strobe outside spi");
    property p_hold; !wr_stb_q |-> $stable({wr_addr_q, wr_data_q}); endproperty
    a_hold: assert property (p_hold) else $error("write word moved");
    property p_pulse; wr_stb_q |=> !wr_stb_q; endproperty
    a_pulse: assert property (p_pulse) else $error("long strobe");
    property p_addr; wr_stb_q && wr_addr_q == 8'h02 |-> ##2 mono_vol_q == wr_data_q[4:0];
    endproperty
    a_addr: assert property (p_addr) else $error("mono not written");
    property p_min; ls_l_vol_q == 5'h01 |=> ls_l_gain_q == 8'sh90; endproperty
    a_min: assert property (p_min) else $error("min gain");
    property p_mute; ls_l_vol_q == 5'h00 |=> mute_q[4] && ls_l_gain_q == 8'sh00; endproperty
    a_mute: assert property (p_mute) else $error("no mute");
    property p_max; ls_l_vol_q == 5'h1F |=> ls_l_gain_q == 8'sh0A; endproperty
    a_max: assert property (p_max) else $error("max gain");
    property p_drop; frame_select_low_n [*8] |-> !wr_stb_q; endproperty
    a_drop: assert property (p_drop) else $error("strobe while idle");
endmodule
bind acsp_ctrl_port acsp_props u_props (
    .mclk               (mclk),
    .reset_n            (reset_n),
    .frame_select_low_n (frame_select_low_n),
    .spi_mode_q         (spi_mode_q),
    .wr_stb_q           (wr_stb_q),
    .wr_addr_q          (wr_addr_q),
    .wr_data_q          (wr_data_q),
    .ls_l_vol_q         (ls_l_vol_q),
    .mono_vol_q         (mono_vol_q),
    .mute_q             (mute_q),
    .ls_l_gain_q        (ls_l_gain_q)
);

//--- verification/acsp_host_model.sv
// host master model driving the three-wire link
`timescale 1ns/1ps
module acsp_host_model (
    // link pins
    output logic sclk,
    output logic sdi,
    output logic frame_select_low_n
);
    // link idle, clock parked low
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        frame_select_low_n = 1'b1;
    end
    task automatic send(input logic [15:0] f, input int n);
        frame_select_low_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdi = f[i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        #62.5 frame_select_low_n = 1'b1;
        sdi = ~sdi;
        #250;
    endtask
endmodule

//--- verification/test_audio_control_serial_port.sv
// self-checking bench for the control port
`timescale 1ns/1ps
module test_audio_control_serial_port;
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic       mode_strap = 1'b1;
    logic       addr_strap = 1'b0;
    logic       sclk, sdi, frame_select_low_n, spi_mode_q, wr_stb_q;
    logic [6:0] i2c_addr_q;
    logic [7:0] wr_addr_q, wr_data_q, ls_l_gain_q;
    logic [4:0] ls_l_vol_q, ls_r_vol_q, hp_l_vol_q, hp_r_vol_q, mono_vol_q, mute_q;
    int         err_count = 0;
    int         checks_done = 0;
    acsp_ctrl_port dut (
        .mclk               (mclk),
        .reset_n            (reset_n),
        .mode_strap         (mode_strap),
        .addr_strap         (addr_strap),
        .sclk               (sclk),
        .sdi                (sdi),
        .frame_select_low_n (frame_select_low_n),
        .spi_mode_q         (spi_mode_q),
        .i2c_addr_q         (i2c_addr_q),
        .wr_stb_q           (wr_stb_q),
        .wr_addr_q          (wr_addr_q),
        .wr_data_q          (wr_data_q),
        .ls_l_vol_q         (ls_l_vol_q),
        .ls_r_vol_q         (ls_r_vol_q),
        .hp_l_vol_q         (hp_l_vol_q),
        .hp_r_vol_q         (hp_r_vol_q),
        .mono_vol_q         (mono_vol_q),
        .mute_q             (mute_q),
        .ls_l_gain_q        (ls_l_gain_q)
    );
    acsp_host_model host (
        .sclk               (sclk),
        .sdi                (sdi),
        .frame_select_low_n (frame_select_low_n)
    );
    // system clock
    always #5 mclk = ~mclk;
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        checks_done++;
        if (a !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task automatic rst(input logic m, input logic a);
        @(negedge mclk);
        reset_n = 1'b0;
        mode_strap = m;
        addr_strap = a;
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
    endtask
    task automatic t_volume();
        host.send(16'h0301, 16);
        chk(wr_addr_q, 8'h03);
        chk(ls_l_gain_q, 8'h90);
        host.send(16'h031F, 16);
        chk(ls_l_gain_q, 8'h0A);
        host.send(16'h0300, 16);
        chk({3'h0, mute_q}, 8'h1F);
        chk(ls_l_gain_q, 8'h00);
        host.send(16'h02A5, 16);
        chk({3'h0, mono_vol_q}, 8'h05);
        chk({3'h0, mute_q}, 8'h1E);
    endtask
    task automatic t_partial();
        host.send(16'h021F, 12);
        chk({3'h0, mono_vol_q}, 8'h05);
    endtask
    // remaining outputs, a step above the lowest code, out-of-range address
    task automatic t_channels();
        host.send(16'h0411, 16);
        chk({3'h0, ls_r_vol_q}, 8'h11);
        host.send(16'h0512, 16);
        chk({3'h0, hp_l_vol_q}, 8'h12);
        chk(wr_data_q, 8'h12);
        host.send(16'h06E7, 16);
        chk({3'h0, hp_r_vol_q}, 8'h07);
        chk({3'h0, mute_q}, 8'h10);
        host.send(16'h1303, 16);
        chk(wr_addr_q, 8'h13);
        chk({3'h0, ls_l_vol_q}, 8'h00);
        host.send(16'h0302, 16);
        chk(ls_l_gain_q, 8'h94);
    endtask
    task automatic t_i2c();
        rst(1'b0, 1'b1);
        chk({1'b0, i2c_addr_q}, 8'h70);
        chk({7'h00, spi_mode_q}, 8'h00);
        host.send(16'h0203, 16);
        chk({3'h0, mono_vol_q}, 8'h00);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst(1'b1, 1'b0);
        chk({1'b0, i2c_addr_q}, 8'h10);
        chk({7'h00, spi_mode_q}, 8'h01);
        t_volume();
        t_partial();
        t_channels();
        t_i2c();
        results();
    end
    // hang guard
    initial begin
        #200000;
        err_count++;
        results();
    end
endmodule
